/* core/csp_pkg.sv */
/*
  csp_pkg: constants, layouts and types shared by the processing-state
  sequencer (device end) and the core/peripheral model (host end).
  Assumes a single 50 MHz clock domain for both ends.
*/
`default_nettype none
package csp_pkg;
  // power-down control register layout
  localparam int PDC_W = 8;
  localparam int PDC_DEPTH_BIT = 7;
  localparam int MSTP_W = 5;
  localparam int MOD_PRODUCT_UNIT = 4;
  localparam int MOD_DIV = 3;
  localparam int MOD_FRT = 2;
  localparam int MOD_SCI = 1;
  localparam int MOD_DMA = 0;
  localparam logic [PDC_W-1:0] PDC_RST = 8'h00;
  // modules whose registers survive a clock stop
  localparam logic [MSTP_W-1:0] REG_KEEP_MASK = 5'h19;

  // vector table and stack layout (byte addresses)
  localparam logic [31:0] VEC_PC_ADDR = 32'h0000_0000;
  localparam logic [31:0] VEC_SP_ADDR = 32'h0000_0004;
  localparam logic [31:0] VEC_IRQ_ADDR = 32'h0000_0008;
  localparam logic [31:0] VEC_DMAERR_ADDR = 32'h0000_000c;
  localparam logic [31:0] VEC_NMI_ADDR = 32'h0000_0010;
  localparam logic [31:0] STK_WORD = 32'h0000_0004;
  localparam logic [31:0] STK_TWO = 32'h0000_0008;

  // oscillator stabilization wait
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned OSC_STAB_NS = 100000;
  localparam int unsigned OSC_STAB_CYC = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_CNT_W = 16;

  // host register map (byte offsets)
  localparam logic [5:0] HR_CTRL = 6'h00;
  localparam logic [5:0] HR_PDC = 6'h04;
  localparam logic [5:0] HR_SP = 6'h08;
  localparam logic [5:0] HR_PC = 6'h0c;
  localparam logic [5:0] HR_SR = 6'h10;
  localparam logic [5:0] HR_STATUS = 6'h14;
  localparam int HR_MEM_BIT = 5;
  localparam int MEM_DEPTH = 8;

  // host control bits
  localparam int CB_HALT = 0;
  localparam int CB_DMAERR = 1;
  localparam int CB_IRQ = 2;
  localparam int CB_BUSREQ = 3;
  localparam int CB_DMAME = 4;
  localparam int CB_CACHE = 5;
  localparam int CB_MACOP = 6;
  localparam int CB_MULBUSY = 7;

  // host status bits
  localparam int SB_STATE = 0;
  localparam int SB_CPUCLK = 3;
  localparam int SB_PERCLK = 4;
  localparam int SB_OSC = 5;
  localparam int SB_GRANT = 6;
  localparam int SB_POR = 7;
  localparam int SB_MANUAL = 8;
  localparam int SB_MACINV = 9;
  localparam int SB_RAMUNDEF = 10;
  localparam int SB_REFUSED = 11;
  localparam int SB_MODCLK = 16;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_EXC = 3'b001,
    ST_BUSREL = 3'b010,
    ST_EXEC = 3'b011,
    ST_PDOWN = 3'b100
  } csp_state_e;

  // word index of a bus address into the host's small memory
  function automatic logic [2:0] csp_mem_idx(input logic [31:0] a);
    csp_mem_idx = a[4:2];
  endfunction : csp_mem_idx
endpackage : csp_pkg
`default_nettype wire

/* core/csp_if.sv */
/*
  csp_if: signals between the processing-state sequencer and the
  core/peripheral side. Assumes both ends share mclk.
*/
`default_nettype none
interface csp_if;
  import csp_pkg::*;
  // sequencer to core side
  logic cyc_req;
  logic cyc_we;
  logic [31:0] cyc_addr;
  logic [31:0] cyc_wdata;
  logic pc_load;
  logic [31:0] pc_val;
  logic sp_load;
  logic [31:0] sp_val;
  logic cpu_clk_en;
  logic periph_clk_en;
  logic osc_en;
  logic periph_init;
  logic [MSTP_W-1:0] mod_clk_en;
  logic [MSTP_W-1:0] mod_pin_rst;
  logic [MSTP_W-1:0] mod_reg_init;
  logic [MSTP_W-1:0] vec_hold;
  logic bus_grant;
  logic cpu_hold;
  logic mac_invalid;
  logic ram_undef;
  logic por_flag;
  logic manual_flag;
  logic [PDC_W-1:0] pdc_rdata;
  logic [2:0] proc_state;
  // core side to sequencer
  logic cyc_ack;
  logic [31:0] cyc_rdata;
  logic halt_exec;
  logic irq_req;
  logic dma_addr_err;
  logic bus_req;
  logic product_unit_busy;
  logic [31:0] cur_pc;
  logic [31:0] cur_sp;
  logic [31:0] cur_sr;
  logic pdc_wr;
  logic [PDC_W-1:0] pdc_wdata;

  modport dev (
    output cyc_req, cyc_we, cyc_addr, cyc_wdata, pc_load, pc_val, sp_load, sp_val,
    output cpu_clk_en, periph_clk_en, osc_en, periph_init, mod_clk_en, mod_pin_rst,
    output mod_reg_init, vec_hold, bus_grant, cpu_hold, mac_invalid, ram_undef,
    output por_flag, manual_flag, pdc_rdata, proc_state,
    input cyc_ack, cyc_rdata, halt_exec, irq_req, dma_addr_err, bus_req, product_unit_busy,
    input cur_pc, cur_sp, cur_sr, pdc_wr, pdc_wdata
  );
  modport host (
    input cyc_req, cyc_we, cyc_addr, cyc_wdata, pc_load, pc_val, sp_load, sp_val,
    input cpu_clk_en, periph_clk_en, osc_en, periph_init, mod_clk_en, mod_pin_rst,
    input mod_reg_init, vec_hold, bus_grant, cpu_hold, mac_invalid, ram_undef,
    input por_flag, manual_flag, pdc_rdata, proc_state,
    output cyc_ack, cyc_rdata, halt_exec, irq_req, dma_addr_err, bus_req, product_unit_busy,
    output cur_pc, cur_sp, cur_sr, pdc_wr, pdc_wdata
  );
endinterface : csp_if
`default_nettype wire

/* core/csp_dev.sv */
/*
  csp_dev: processing-state sequencer with power-down control register,
  exception entry engine, sleep/standby and module clock stop.
  Assumes the external init pin and nmi pin are synchronous to mclk and
  that the core side answers each memory cycle with cyc_ack.
*/
// Notes on behaviour
// - five states: reset, exception, released, execute, power-down
// - init pin low resets; nmi level picks kind
// - reset exception loads pc and sp from vectors
// - interrupt pushes pc, status word, then vectors
// - halt with depth bit 0 enters sleep
// - sleep exits on reset, interrupt, transfer error
// - halt with depth bit 1 stops everything
// - software clears transfer master enable before standby
// - busy multiply at standby marks accumulator invalid
// - standby keeps cpu registers, ram undefined
// - standby exits on reset or nmi after wait
// - software disables cache before standby
// - five clock stop bits at positions 4..0
// - stopped module pins reset, some registers initialized
// - stopped modules keep interrupt vector settings
// - writing 0 restores a stopped module clock
// - no accumulator instructions while multiplier stopped
// - clear transfer master enable before stopping it
// - bus request releases bus until it ends
`default_nettype none
module csp_dev
  import csp_pkg::*;
#(
  parameter int unsigned OSC_STAB_CYC_P = OSC_STAB_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic external_init_pin_n,
  input wire logic nmi_pin,
  csp_if.dev link
);
  csp_state_e state, next_state;
  logic [31:0] exc_vec, next_vec;
  logic exc_is_rst, next_is_rst;
  logic nmi_q;
  logic nmi_rise;
  logic pd_standby;
  logic next_sby;
  logic osc_wait;
  logic osc_start;
  logic [OSC_CNT_W-1:0] osc_cnt;
  logic halt_all;
  logic stby_entry;
  logic [1:0] exc_step;
  logic cyc_pend;
  logic exc_done;
  logic [31:0] pc_tmp;
  logic [MSTP_W-1:0] stop_bits;

  assign nmi_rise = nmi_pin & ~nmi_q;
  assign stop_bits = link.pdc_rdata[MSTP_W-1:0];
  assign stby_entry = (state == ST_EXEC) && (next_state == ST_PDOWN) && link.pdc_rdata[PDC_DEPTH_BIT];
  // wake from standby starts the wait; nmi during the wait is ignored
  assign osc_start = (state == ST_PDOWN) && pd_standby && !osc_wait
                     && (nmi_rise || !external_init_pin_n);
  assign next_sby = ((state == ST_EXEC) && (next_state == ST_PDOWN)) ? link.pdc_rdata[PDC_DEPTH_BIT] : pd_standby;
  // clocks stay off until the stabilization count has run out
  assign halt_all = ((next_state == ST_PDOWN) && next_sby)
                    || ((next_state == ST_RESET) && (osc_wait || osc_start));

  // next processing state and the vector the exception engine will use
  always_comb begin
    next_state = state;
    next_vec = exc_vec;
    next_is_rst = exc_is_rst;
    if (!external_init_pin_n) begin
      next_state = ST_RESET;
    end else begin
      case (state)
        ST_RESET: begin
          if (!osc_wait || (osc_cnt == '0)) begin
            next_state = ST_EXC;
            next_vec = VEC_PC_ADDR;
            next_is_rst = 1'b1;
          end
        end
        ST_EXC: begin
          if (exc_done) begin
            next_state = ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (link.bus_req) begin
            next_state = ST_BUSREL;
          end else if (link.halt_exec) begin
            next_state = ST_PDOWN;
          end else if (link.dma_addr_err) begin
            next_state = ST_EXC;
            next_vec = VEC_DMAERR_ADDR;
            next_is_rst = 1'b0;
          end else if (link.irq_req) begin
            next_state = ST_EXC;
            next_vec = VEC_IRQ_ADDR;
            next_is_rst = 1'b0;
          end
        end
        ST_BUSREL: begin
          if (!link.bus_req) begin
            next_state = ST_EXEC;
          end
        end
        ST_PDOWN: begin
          if (!pd_standby) begin
            if (link.dma_addr_err) begin
              next_state = ST_EXC;
              next_vec = VEC_DMAERR_ADDR;
              next_is_rst = 1'b0;
            end else if (link.irq_req) begin
              next_state = ST_EXC;
              next_vec = VEC_IRQ_ADDR;
              next_is_rst = 1'b0;
            end
          end else if (osc_wait && (osc_cnt == '0)) begin
            next_state = ST_EXC;
            next_vec = VEC_NMI_ADDR;
            next_is_rst = 1'b0;
          end
        end
        default: begin
          next_state = ST_RESET;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_RESET;
      exc_vec <= VEC_PC_ADDR;
      exc_is_rst <= 1'b1;
      nmi_q <= 1'b0;
    end else begin
      state <= next_state;
      exc_vec <= next_vec;
      exc_is_rst <= next_is_rst;
      nmi_q <= nmi_pin;
    end
  end

  // sleep or standby is chosen at the moment the halt is taken
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pd_standby <= 1'b0;
    end else if (state == ST_EXEC && next_state == ST_PDOWN) begin
      pd_standby <= link.pdc_rdata[PDC_DEPTH_BIT];
    end
  end

  // oscillator stabilization counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      osc_wait <= 1'b0;
      osc_cnt <= '0;
    end else if (osc_start) begin
      osc_wait <= 1'b1;
      osc_cnt <= OSC_CNT_W'(OSC_STAB_CYC_P - 1);
    end else if (osc_wait && (next_state == ST_EXC)) begin
      osc_wait <= 1'b0;
    end else if (osc_wait && (osc_cnt != '0)) begin
      osc_cnt <= osc_cnt - 1'b1;
    end
  end

  // power-down control register; the init pin returns it to reset value
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.pdc_rdata <= PDC_RST;
    end else if (!external_init_pin_n) begin
      link.pdc_rdata <= PDC_RST;
    end else if (link.pdc_wr) begin
      link.pdc_rdata <= link.pdc_wdata;
    end
  end

  // clock and module control outputs, decoded from the coming state and the stop bits
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.cpu_clk_en <= 1'b1;
      link.periph_clk_en <= 1'b1;
      link.osc_en <= 1'b1;
      link.periph_init <= 1'b0;
      link.mod_clk_en <= '1;
      link.mod_pin_rst <= '0;
      link.mod_reg_init <= '0;
      link.vec_hold <= '0;
      link.bus_grant <= 1'b0;
      link.cpu_hold <= 1'b0;
      link.proc_state <= ST_RESET;
    end else begin
      link.cpu_clk_en <= (next_state != ST_PDOWN) && !halt_all;
      link.periph_clk_en <= !halt_all;
      link.osc_en <= !halt_all;
      link.periph_init <= halt_all;
      link.mod_clk_en <= halt_all ? '0 : ~stop_bits;
      link.mod_pin_rst <= stop_bits;
      link.mod_reg_init <= stop_bits & ~REG_KEEP_MASK;
      link.vec_hold <= stop_bits;
      link.bus_grant <= (next_state == ST_BUSREL);
      link.cpu_hold <= (next_state == ST_PDOWN);
      link.proc_state <= next_state;
    end
  end

  // reset kind and standby side effects; set beats the reset-pin clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.por_flag <= 1'b0;
      link.manual_flag <= 1'b0;
      link.mac_invalid <= 1'b0;
      link.ram_undef <= 1'b0;
    end else begin
      if (!external_init_pin_n) begin
        link.por_flag <= nmi_pin;
        link.manual_flag <= !nmi_pin;
      end
      if (stby_entry && link.product_unit_busy) begin
        link.mac_invalid <= 1'b1;
      end else if (!external_init_pin_n) begin
        link.mac_invalid <= 1'b0;
      end
      if (stby_entry) begin
        link.ram_undef <= 1'b1;
      end else if (!external_init_pin_n) begin
        link.ram_undef <= 1'b0;
      end
    end
  end

  // exception entry engine: one memory cycle per step, waits for ack
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      exc_step <= '0;
      cyc_pend <= 1'b0;
      exc_done <= 1'b0;
      pc_tmp <= '0;
      link.cyc_req <= 1'b0;
      link.cyc_we <= 1'b0;
      link.cyc_addr <= '0;
      link.cyc_wdata <= '0;
      link.pc_load <= 1'b0;
      link.pc_val <= '0;
      link.sp_load <= 1'b0;
      link.sp_val <= '0;
    end else begin
      link.pc_load <= 1'b0;
      link.sp_load <= 1'b0;
      link.cyc_req <= 1'b0;
      if (state != ST_EXC) begin
        exc_step <= '0;
        cyc_pend <= 1'b0;
        exc_done <= 1'b0;
      end else if (!exc_done && !cyc_pend) begin
        cyc_pend <= 1'b1;
        link.cyc_req <= 1'b1;
        if (exc_is_rst) begin
          link.cyc_we <= 1'b0;
          link.cyc_addr <= (exc_step == 2'd0) ? exc_vec : VEC_SP_ADDR;
        end else if (exc_step == 2'd0) begin
          link.cyc_we <= 1'b1;
          link.cyc_addr <= link.cur_sp - STK_WORD;
          link.cyc_wdata <= link.cur_pc;
        end else if (exc_step == 2'd1) begin
          link.cyc_we <= 1'b1;
          link.cyc_addr <= link.cur_sp - STK_TWO;
          link.cyc_wdata <= link.cur_sr;
        end else begin
          link.cyc_we <= 1'b0;
          link.cyc_addr <= exc_vec;
        end
      end else if (!exc_done && link.cyc_ack) begin
        cyc_pend <= 1'b0;
        exc_step <= exc_step + 1'b1;
        if (exc_is_rst && exc_step == 2'd0) begin
          pc_tmp <= link.cyc_rdata;
        end else if (exc_is_rst) begin
          link.pc_val <= pc_tmp;
          link.sp_val <= link.cyc_rdata;
          link.pc_load <= 1'b1;
          link.sp_load <= 1'b1;
          exc_done <= 1'b1;
        end else if (exc_step == 2'd2) begin
          link.pc_val <= link.cyc_rdata;
          link.sp_val <= link.cur_sp - STK_TWO;
          link.pc_load <= 1'b1;
          link.sp_load <= 1'b1;
          exc_done <= 1'b1;
        end
      end
    end
  end
endmodule : csp_dev
`default_nettype wire

/* core/csp_host.sv */
/*
  csp_host: core and peripheral side of the sequencer link. Holds the
  core's pc, sp and status word, a small vector/stack memory, and a
  command register that software drives over a plain register port.
  Assumes read data is taken one cycle after the read strobe.
*/
`default_nettype none
module csp_host
  import csp_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [5:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  csp_if.host link
);
  logic [31:0] mem [MEM_DEPTH];
  logic dma_me;
  logic cache_en;
  logic refused;
  logic want_sby;
  logic halt_bad;
  logic pdc_bad;
  logic mac_bad;
  logic [31:0] status;

  assign want_sby = link.pdc_rdata[PDC_DEPTH_BIT];
  // standby halt is refused while transfers or the cache are enabled
  assign halt_bad = want_sby && (dma_me || cache_en);
  assign pdc_bad = wdata[MOD_DMA] && !link.pdc_rdata[MOD_DMA] && dma_me;
  assign mac_bad = wdata[CB_MACOP] && link.pdc_rdata[MOD_PRODUCT_UNIT];

  always_comb begin
    status = '0;
    status[SB_STATE +: 3] = link.proc_state;
    status[SB_CPUCLK] = link.cpu_clk_en;
    status[SB_PERCLK] = link.periph_clk_en;
    status[SB_OSC] = link.osc_en;
    status[SB_GRANT] = link.bus_grant;
    status[SB_POR] = link.por_flag;
    status[SB_MANUAL] = link.manual_flag;
    status[SB_MACINV] = link.mac_invalid;
    status[SB_RAMUNDEF] = link.ram_undef;
    status[SB_REFUSED] = refused;
    status[SB_MODCLK +: MSTP_W] = link.mod_clk_en;
  end

  // command register: pulses last one cycle, levels hold until rewritten, except irq_req, which pc_load also clears
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.halt_exec <= 1'b0;
      link.dma_addr_err <= 1'b0;
      link.irq_req <= 1'b0;
      link.bus_req <= 1'b0;
      link.product_unit_busy <= 1'b0;
      dma_me <= 1'b0;
      cache_en <= 1'b0;
    end else begin
      link.halt_exec <= 1'b0;
      link.dma_addr_err <= 1'b0;
      if (wr && addr == HR_CTRL) begin
        link.halt_exec <= wdata[CB_HALT] && !halt_bad;
        link.dma_addr_err <= wdata[CB_DMAERR];
        link.irq_req <= wdata[CB_IRQ];
        link.bus_req <= wdata[CB_BUSREQ];
        link.product_unit_busy <= wdata[CB_MULBUSY];
        dma_me <= wdata[CB_DMAME];
        cache_en <= wdata[CB_CACHE];
      end else if (link.pc_load) begin
        link.irq_req <= 1'b0; // taken interrupt acknowledges the request
      end
    end
  end

  // refused flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      refused <= 1'b0;
    end else if ((wr && addr == HR_CTRL && ((wdata[CB_HALT] && halt_bad) || mac_bad))
                 || (wr && addr == HR_PDC && pdc_bad)) begin
      refused <= 1'b1;
    end else if (wr && addr == HR_STATUS && wdata[SB_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  // forward control register writes to the sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.pdc_wr <= 1'b0;
      link.pdc_wdata <= PDC_RST;
    end else begin
      link.pdc_wr <= wr && (addr == HR_PDC) && !pdc_bad;
      if (wr && addr == HR_PDC) begin
        link.pdc_wdata <= wdata[PDC_W-1:0];
      end
    end
  end

  // core registers; loads from the exception engine take priority
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.cur_pc <= '0;
      link.cur_sp <= '0;
      link.cur_sr <= '0;
    end else begin
      if (link.pc_load) begin
        link.cur_pc <= link.pc_val;
      end else if (wr && addr == HR_PC) begin
        link.cur_pc <= wdata;
      end
      if (link.sp_load) begin
        link.cur_sp <= link.sp_val;
      end else if (wr && addr == HR_SP) begin
        link.cur_sp <= wdata;
      end
      if (wr && addr == HR_SR) begin
        link.cur_sr <= wdata;
      end
    end
  end

  // vector/stack memory, answering each engine cycle one clock later
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= '0;
      end
      link.cyc_ack <= 1'b0;
      link.cyc_rdata <= '0;
    end else begin
      link.cyc_ack <= link.cyc_req;
      if (link.cyc_req && link.cyc_we) begin
        mem[csp_mem_idx(link.cyc_addr)] <= link.cyc_wdata;
      end else if (wr && addr[HR_MEM_BIT]) begin
        mem[addr[4:2]] <= wdata;
      end
      if (link.cyc_req && !link.cyc_we) begin
        link.cyc_rdata <= mem[csp_mem_idx(link.cyc_addr)];
      end
    end
  end

  // register read port; unmapped offsets read zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else if (rd) begin
      if (addr[HR_MEM_BIT]) begin
        rdata <= mem[addr[4:2]];
      end else begin
        case (addr)
          HR_CTRL: rdata <= {24'h00_0000, link.product_unit_busy, 1'b0, cache_en, dma_me,
                             link.bus_req, link.irq_req, 2'b00};
          HR_PDC: rdata <= {24'h00_0000, link.pdc_rdata};
          HR_SP: rdata <= link.cur_sp;
          HR_PC: rdata <= link.cur_pc;
          HR_SR: rdata <= link.cur_sr;
          HR_STATUS: rdata <= status;
          default: rdata <= '0;
        endcase
      end
    end else begin
      rdata <= '0;
    end
  end
endmodule : csp_host
`default_nettype wire

/* tb/csp_sva.sv */
/*
  csp_sva: assertions on the link between the sequencer and the core side.
  Assumes one clock domain and an active-low asynchronous reset.
*/
`default_nettype none
module csp_sva
  import csp_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [2:0] proc_state,
  input wire logic cyc_ack,
  input wire logic pc_load,
  input wire logic sp_load,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic osc_en,
  input wire logic [MSTP_W-1:0] mod_clk_en,
  input wire logic [MSTP_W-1:0] mod_pin_rst,
  input wire logic [MSTP_W-1:0] mod_reg_init,
  input wire logic [MSTP_W-1:0] vec_hold,
  input wire logic bus_grant,
  input wire logic ram_undef
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // state and entry checks
  state_legal_a: assert property (proc_state <= ST_PDOWN)
    else $error("illegal state code");
  load_pair_a: assert property (pc_load |-> sp_load && $past(cyc_ack))
    else $error("pc load without sp load or ack");
  sleep_clk_a: assert property (proc_state == ST_PDOWN && periph_clk_en |-> !cpu_clk_en && osc_en)
    else $error("sleep clocks wrong");
  exit_exc_a: assert property ($past(proc_state) == ST_PDOWN && proc_state != ST_PDOWN |->
    proc_state inside {ST_EXC, ST_RESET})
    else $error("power-down left without exception");
  standby_off_a: assert property (!osc_en |-> !cpu_clk_en && !periph_clk_en && mod_clk_en == 5'h00)
    else $error("clock running in standby");
  ram_undef_a: assert property ($fell(osc_en) |-> ##[0:1] ram_undef)
    else $error("ram not marked undefined");
  // clock stop, release and wait
  mod_clk_a: assert property (cpu_clk_en && proc_state != ST_PDOWN |-> mod_clk_en == ~mod_pin_rst)
    else $error("module clock mismatch");
  vec_keep_a: assert property (vec_hold == mod_pin_rst)
    else $error("vector hold mismatch");
  // only the timer and serial port lose their registers when stopped
  reg_init_a: assert property (mod_reg_init == (mod_pin_rst & 5'h06))
    else $error("module register init mismatch");
  bus_grant_a: assert property (bus_grant == (proc_state == ST_BUSREL))
    else $error("grant not tied to released state");
  // cpu clock comes back with the oscillator, not before it
  osc_wait_a: assert property ($rose(osc_en) |-> $rose(cpu_clk_en) && !$past(osc_en, 4))
    else $error("clock released before wait");
endmodule : csp_sva
`default_nettype wire

/* tb/testbench.sv */
/*
  testbench: drives both link ends through the host register port and
  the init and nmi pins. Assumes the oscillator wait is cut to 4 cycles.
*/
`default_nettype none
module testbench
  import csp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic init_n = 1'b1;
  logic nmi = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  csp_if link_if();
  csp_dev #(.OSC_STAB_CYC_P(4)) csp_dev_inst (.mclk(mclk), .arst_n(arst_n), .external_init_pin_n(init_n),
    .nmi_pin(nmi), .link(link_if));
  csp_host csp_host_inst (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link(link_if));
  csp_sva csp_sva_inst (.mclk(mclk), .arst_n(arst_n), .proc_state(link_if.proc_state),
    .cyc_ack(link_if.cyc_ack), .pc_load(link_if.pc_load), .sp_load(link_if.sp_load),
    .cpu_clk_en(link_if.cpu_clk_en), .periph_clk_en(link_if.periph_clk_en), .osc_en(link_if.osc_en),
    .mod_clk_en(link_if.mod_clk_en), .mod_pin_rst(link_if.mod_pin_rst), .vec_hold(link_if.vec_hold),
    .bus_grant(link_if.bus_grant), .ram_undef(link_if.ram_undef), .mod_reg_init(link_if.mod_reg_init));
  // 50 MHz clock
  initial begin
    forever #10 mclk = ~mclk;
  end
  // hang guard: the run needs well under this many cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // poll a register until its masked value equals exp, bounded to 60 reads
  task automatic wait_reg(input string what, input logic [5:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] v;
    int n;
    n = 0;
    do begin
      rd_reg(a, v);
      n++;
    end while ((v & m) !== exp && n < 60);
    chk(what, v & m, exp);
  endtask : wait_reg
  task automatic t_reset();
    for (int k = 0; k < 2; k++) begin
      // zeroed first, so only the reset exception can bring them back
      wr_reg(HR_SP, 32'h0000_0000);
      wr_reg(HR_PC, 32'h0000_0000);
      @(posedge mclk);
      init_n <= 1'b0;
      nmi <= k[0];
      repeat (3) @(posedge mclk);
      init_n <= 1'b1;
      nmi <= 1'b0;
      wait_reg("sp", HR_SP, 32'hffff_ffff, 32'h0000_0020);
      wait_reg("pc", HR_PC, 32'hffff_ffff, 32'h0000_1000);
      wait_reg("status", HR_STATUS, 32'hffff_ffff, k ? 32'h001f_00bb : 32'h001f_013b);
    end
  endtask : t_reset
  task automatic t_irq();
    wr_reg(HR_SR, 32'h0000_00f0);
    wr_reg(HR_CTRL, 32'h0000_0004);
    wait_reg("irq pc", HR_PC, 32'hffff_ffff, 32'h0000_2000);
    wait_reg("irq sp", HR_SP, 32'hffff_ffff, 32'h0000_0018);
    wait_reg("saved pc", 6'h3c, 32'hffff_ffff, 32'h0000_1000);
    wait_reg("saved sr", 6'h38, 32'hffff_ffff, 32'h0000_00f0);
  endtask : t_irq
  task automatic t_sleep();
    wr_reg(HR_PDC, 32'h0000_0000);
    wr_reg(HR_CTRL, 32'h0000_0001);
    wait_reg("sleep", HR_STATUS, 32'h0000_003f, 32'h0000_0034);
    wr_reg(HR_CTRL, 32'h0000_0002);
    wait_reg("wake", HR_PC, 32'hffff_ffff, 32'h0000_3000);
  endtask : t_sleep
  // the sleep exit pushed over the nmi vector, so it is written again
  task automatic t_standby();
    wr_reg(6'h30, 32'h0000_4000);
    wr_reg(HR_PDC, 32'h0000_0080);
    wr_reg(HR_CTRL, 32'h0000_0081);
    wait_reg("standby", HR_STATUS, 32'h0000_067f, 32'h0000_0604);
    @(posedge mclk);
    nmi <= 1'b1;
    wait_reg("nmi pc", HR_PC, 32'hffff_ffff, 32'h0000_4000);
    @(posedge mclk);
    nmi <= 1'b0;
  endtask : t_standby
  task automatic t_mod();
    logic [4:0] s;
    for (int i = 0; i < 6; i++) begin
      s = 5'(32'h1 << i);
      wr_reg(HR_PDC, {27'h0, s});
      wait_reg("modclk", HR_STATUS, 32'h001f_0007, {11'h0, ~s, 16'h3});
    end
  endtask : t_mod
  task automatic t_bus();
    wr_reg(HR_CTRL, 32'h0000_0008);
    wait_reg("grant", HR_STATUS, 32'h0000_0047, 32'h0000_0042);
    wr_reg(HR_CTRL, 32'h0000_0000);
    wait_reg("ungrant", HR_STATUS, 32'h0000_0047, 32'h0000_0003);
  endtask : t_bus
  // refusals keep state and settings and raise the flag; status polled before pdc
  task automatic t_refuse();
    wr_reg(HR_PDC, 32'h0000_0080);
    for (int k = 0; k < 4; k++) begin
      wr_reg(k == 2 ? HR_PDC : HR_CTRL, k == 1 ? 32'h0000_0020 : 32'h0000_0010);
      wr_reg(HR_STATUS, 32'h0000_0800);
      wait_reg("unrefused", HR_STATUS, 32'h0000_0800, 32'h0000_0000);
      wr_reg(k == 3 ? HR_PDC : HR_CTRL, k == 1 ? 32'h0000_0021 : k == 2 ? 32'h0000_0040 : 32'h0000_0011);
      wait_reg("refused", HR_STATUS, 32'h0000_0807, 32'h0000_0803);
    end
    wait_reg("pdc kept", HR_PDC, 32'h0000_00ff, 32'h0000_0010);
  endtask : t_refuse
  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    wr_reg(6'h20, 32'h0000_1000);
    wr_reg(6'h24, 32'h0000_0020);
    wr_reg(6'h28, 32'h0000_2000);
    wr_reg(6'h2c, 32'h0000_3000);
    t_reset();
    t_irq();
    t_sleep();
    t_standby();
    t_mod();
    t_bus();
    t_refuse();
    close_out();
  end
endmodule : testbench
`default_nettype wire
